// >>> ssx_alu.sv
`timescale 1ns/100ps
// Subtract and nibble-exchange datapath, purely combinational
module ssx_alu #(
  parameter int DATA_W = 8
) (
  // Operands
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  // Results
  output logic      [DATA_W-1:0] diff,
  output logic      [DATA_W-1:0] swapped,
  output logic                   no_borrow,
  output logic                   digit_no_borrow,
  output logic                   is_zero
);
  initial begin
    if (DATA_W != 8) $error("ssx_alu supports only 8-bit data");
  end
  // Full and low-nibble differences with borrow bits
  logic [DATA_W:0] full_d;
  logic [4:0]      low_d;
  always_comb begin
    full_d          = {1'b0, minuend} - {1'b0, subtrahend};
    low_d           = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    diff            = full_d[DATA_W-1:0];
    no_borrow       = ~full_d[DATA_W];
    digit_no_borrow = ~low_d[4];
    is_zero         = (full_d[DATA_W-1:0] == '0);
    swapped         = {minuend[3:0], minuend[7:4]};
  end
endmodule

// >>> ssx_core.sv
`timescale 1ns/100ps
// Behaviour
// - Literal-subtract computes literal minus accumulator
// - Literal-subtract result replaces accumulator
// - Literal-subtract decoded as 11 110x kkkkkkkk
// - One cycle: decode, read, process, write
// - Subtracts update carry, digit carry, zero only
// - Carry set on no borrow; zero on zero
// - Register-subtract: file minus acc, destination selectable
// - Opcode 00 1110 swaps file nibbles, no flags
// - Swap destination bit picks acc or file
// - Sleep decoded Q1, idle Q2-Q3, sleeps Q4
// - Sleep clears watchdog, prescaler; sets timeout, clears powerdown
// - Sleep code is 00 0000 0110 0011
module ssx_core #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Instruction input, sampled at phase one
  input  wire logic [13:0]       instr_word,
  input  wire logic              instr_valid,
  // File register read data for the addressed register
  input  wire logic [DATA_W-1:0] file_rdata,
  // File register write port
  output logic      [ADDR_W-1:0] file_addr,
  output logic      [DATA_W-1:0] file_wdata,
  output logic                   file_we,
  // Accumulator and status flags
  output logic      [DATA_W-1:0] acc,
  output logic                   carry_flag,
  output logic                   digit_carry_flag,
  output logic                   zero_flag,
  output logic                   timeout_status_bit,
  output logic                   powerdown_status_bit,
  // Power control
  output logic                   sleep_state,
  output logic      [7:0]        watchdog_counter,
  output logic      [7:0]        watchdog_prescaler,
  // Phase indicator
  output logic      [3:0]        phase
);
  initial begin
    if (DATA_W != ssx_pkg::DATA_W) $error("ssx_core needs 8-bit data");
    if (ADDR_W != ssx_pkg::ADDR_W) $error("ssx_core needs 7-bit file address");
  end

  // Phase sequencer state
  ssx_pkg::ssx_phase_e phase_r;
  // Latched instruction fields
  ssx_pkg::ssx_op_e    op_r;
  logic [DATA_W-1:0]   lit_r;
  logic                dest_r;
  logic [ADDR_W-1:0]   addr_r;
  // Operand captured in phase two, result captured in phase three
  logic [DATA_W-1:0]   opnd_r;
  logic [DATA_W-1:0]   res_r;
  logic                c_r;
  logic                dc_r;
  logic                z_r;
  // Register copies of outputs
  logic [DATA_W-1:0]   acc_r;
  logic                carry_r;
  logic                dcarry_r;
  logic                zero_r;
  logic                to_r;
  logic                pd_r;
  logic                sleep_r;
  logic [7:0]          wdt_r;
  logic [7:0]          pre_r;
  logic [DATA_W-1:0]   fwd_r;
  logic                fwe_r;
  // Datapath results
  logic [DATA_W-1:0]   alu_diff;
  logic [DATA_W-1:0]   alu_swap;
  logic                alu_nb;
  logic                alu_dnb;
  logic                alu_z;
  ssx_pkg::ssx_op_e    dec_op;

  // Opcode decoder
  function automatic ssx_pkg::ssx_op_e ssx_decode(input logic [13:0] w);
    ssx_pkg::ssx_op_e o;
    o = ssx_pkg::SSX_OP_NONE;
    if (w[13:12] == ssx_pkg::TOP_LIT && w[11:9] == ssx_pkg::SUBL_HI) begin
      o = ssx_pkg::SSX_OP_SUBL;
    end else if (w == ssx_pkg::SLEEP_CODE) begin
      o = ssx_pkg::SSX_OP_SLEEP;
    end else if (w[13:12] == ssx_pkg::TOP_REG && w[11:8] == ssx_pkg::SUBR_OP) begin
      o = ssx_pkg::SSX_OP_SUBR;
    end else if (w[13:12] == ssx_pkg::TOP_REG && w[11:8] == ssx_pkg::SWAP_OP) begin
      o = ssx_pkg::SSX_OP_SWAP;
    end
    return o;
  endfunction

  assign dec_op = ssx_decode(instr_word);

  // Subtract and swap datapath
  ssx_alu #(
    .DATA_W (DATA_W)
  ) u_alu (
    .minuend         (opnd_r),
    .subtrahend      (acc_r),
    .diff            (alu_diff),
    .swapped         (alu_swap),
    .no_borrow       (alu_nb),
    .digit_no_borrow (alu_dnb),
    .is_zero         (alu_z)
  );

  // Four-phase sequencer, one instruction per loop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= ssx_pkg::SSX_Q1;
    end else begin
      unique case (phase_r)
        ssx_pkg::SSX_Q1: phase_r <= ssx_pkg::SSX_Q2;
        ssx_pkg::SSX_Q2: phase_r <= ssx_pkg::SSX_Q3;
        ssx_pkg::SSX_Q3: phase_r <= ssx_pkg::SSX_Q4;
        ssx_pkg::SSX_Q4: phase_r <= ssx_pkg::SSX_Q1;
        default:         phase_r <= ssx_pkg::SSX_Q1;
      endcase
    end
  end

  // Phase one: decode and latch fields; sleep halts further decode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      op_r   <= ssx_pkg::SSX_OP_NONE;
      lit_r  <= '0;
      dest_r <= 1'b0;
      addr_r <= '0;
    end else if (phase_r == ssx_pkg::SSX_Q1) begin
      op_r   <= (instr_valid && !sleep_r) ? dec_op : ssx_pkg::SSX_OP_NONE;
      lit_r  <= instr_word[7:0];
      dest_r <= instr_word[ssx_pkg::DEST_BIT];
      addr_r <= instr_word[6:0];
    end
  end

  // Phase two: read the literal or the file register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      opnd_r <= '0;
    end else if (phase_r == ssx_pkg::SSX_Q2) begin
      opnd_r <= (op_r == ssx_pkg::SSX_OP_SUBL) ? lit_r : file_rdata;
    end
  end

  // Phase three: process data
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      res_r <= '0;
      c_r   <= 1'b0;
      dc_r  <= 1'b0;
      z_r   <= 1'b0;
    end else if (phase_r == ssx_pkg::SSX_Q3) begin
      res_r <= (op_r == ssx_pkg::SSX_OP_SWAP) ? alu_swap : alu_diff;
      c_r   <= alu_nb;
      dc_r  <= alu_dnb;
      z_r   <= alu_z;
    end
  end

  // Phase four: accumulator write-back
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= ssx_pkg::ACC_RST;
    end else if (phase_r == ssx_pkg::SSX_Q4) begin
      if (op_r == ssx_pkg::SSX_OP_SUBL) begin
        acc_r <= res_r;
      end else if ((op_r == ssx_pkg::SSX_OP_SUBR || op_r == ssx_pkg::SSX_OP_SWAP) && !dest_r) begin
        acc_r <= res_r;
      end
    end
  end

  // Phase four: file register write-back, pulse one cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fwe_r  <= 1'b0;
      fwd_r  <= '0;
    end else begin
      fwe_r <= (phase_r == ssx_pkg::SSX_Q4) && dest_r &&
               (op_r == ssx_pkg::SSX_OP_SUBR || op_r == ssx_pkg::SSX_OP_SWAP);
      fwd_r <= res_r;
    end
  end

  // Phase four: arithmetic flags, subtracts only; swap leaves them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      carry_r  <= 1'b0;
      dcarry_r <= 1'b0;
      zero_r   <= 1'b0;
    end else if (phase_r == ssx_pkg::SSX_Q4 &&
                 (op_r == ssx_pkg::SSX_OP_SUBL || op_r == ssx_pkg::SSX_OP_SUBR)) begin
      carry_r  <= c_r;
      dcarry_r <= dc_r;
      zero_r   <= z_r;
    end
  end

  // Phase four: sleep entry with watchdog and status updates
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_r <= 1'b0;
      to_r    <= 1'b1;
      pd_r    <= 1'b1;
      wdt_r   <= ssx_pkg::WDT_RST;
      pre_r   <= ssx_pkg::PRE_RST;
    end else if (phase_r == ssx_pkg::SSX_Q4 && op_r == ssx_pkg::SSX_OP_SLEEP) begin
      sleep_r <= 1'b1;
      wdt_r   <= ssx_pkg::WDT_RST;
      pre_r   <= ssx_pkg::PRE_RST;
      to_r    <= 1'b1;
      pd_r    <= 1'b0;
    end
  end

  // Outputs straight from flip-flops
  assign phase                = phase_r;
  assign acc                  = acc_r;
  assign carry_flag           = carry_r;
  assign digit_carry_flag     = dcarry_r;
  assign zero_flag            = zero_r;
  assign timeout_status_bit   = to_r;
  assign powerdown_status_bit = pd_r;
  assign sleep_state          = sleep_r;
  assign watchdog_counter     = wdt_r;
  assign watchdog_prescaler   = pre_r;
  assign file_addr            = addr_r;
  assign file_wdata           = fwd_r;
  assign file_we              = fwe_r;
endmodule

// >>> ssx_core_props.sv
`timescale 1ns/100ps
// Cycle and result checks on the core
module ssx_core_props (
  // Inputs
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [13:0] instr_word,
  input wire logic        instr_valid,
  input wire logic [7:0]  file_rdata,
  // Outputs
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic [7:0]  acc,
  input wire logic        carry_flag,
  input wire logic        digit_carry_flag,
  input wire logic        zero_flag,
  input wire logic        timeout_status_bit,
  input wire logic        powerdown_status_bit,
  input wire logic        sleep_state,
  input wire logic [7:0]  watchdog_counter,
  input wire logic [3:0]  phase
);
  // Instruction taken in this phase-one cycle
  wire go  = phase == 4'h1 && instr_valid && !sleep_state;
  wire lit = go && instr_word[13:9] == 5'h1e;
  wire swp = go && instr_word[13:8] == 6'h0e;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  phase_rotate_a: assert property (!sleep_state |=>
    phase == {$past(phase[2:0]), $past(phase[3])}) else $error("phase out of order");
  acc_hold_a: assert property (phase != 4'h8 |=>
    $stable({acc, carry_flag, digit_carry_flag, zero_flag})) else $error("early write");
  lit_result_a: assert property (lit |-> ##4
    acc == $past(instr_word[7:0], 4) - $past(acc, 4)) else $error("bad difference");
  lit_borrow_a: assert property (lit |-> ##4
    carry_flag == ($past(instr_word[7:0], 4) >= $past(acc, 4)) &&
    digit_carry_flag == ($past(instr_word[3:0], 4) >= $past(acc[3:0], 4)))
    else $error("bad borrow flags");
  zero_match_a: assert property (lit |-> ##4
    zero_flag == (acc == 8'h00)) else $error("bad zero flag");
  swap_write_a: assert property (swp && instr_word[7] |-> ##4 file_we &&
    file_wdata == {$past(file_rdata[3:0], 3), $past(file_rdata[7:4], 3)})
    else $error("bad swap write");
  swap_flags_a: assert property (swp |-> ##4
    $stable({carry_flag, digit_carry_flag, zero_flag})) else $error("swap moved flags");
  sleep_enter_a: assert property (go && instr_word == 14'h0063 |-> ##3
    !sleep_state ##1 sleep_state && timeout_status_bit && !powerdown_status_bit &&
    watchdog_counter == 8'h00) else $error("bad sleep entry");
endmodule
bind ssx_core ssx_core_props u_props (.core_clk, .nrst, .instr_word, .instr_valid,
  .file_rdata, .file_wdata, .file_we, .acc, .carry_flag, .digit_carry_flag, .zero_flag,
  .timeout_status_bit, .powerdown_status_bit, .sleep_state, .watchdog_counter, .phase);

// >>> ssx_pkg.sv
package ssx_pkg;
  // Instruction word layout
  localparam int INSTR_W   = 14;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 7;
  localparam int DEST_BIT  = 7;
  // Opcode patterns
  localparam logic [1:0]  TOP_LIT     = 2'h3;
  localparam logic [2:0]  SUBL_HI     = 3'h6;
  localparam logic [1:0]  TOP_REG     = 2'h0;
  localparam logic [3:0]  SUBR_OP     = 4'h2;
  localparam logic [3:0]  SWAP_OP     = 4'he;
  localparam logic [13:0] SLEEP_CODE  = 14'h0063;
  // Reset values
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  WDT_RST     = 8'h00;
  localparam logic [7:0]  PRE_RST     = 8'h00;
  // Phase encodings, one-hot
  typedef enum logic [3:0] {
    SSX_Q1 = 4'h1,
    SSX_Q2 = 4'h2,
    SSX_Q3 = 4'h4,
    SSX_Q4 = 4'h8
  } ssx_phase_e;
  // Decoded operation classes
  typedef enum logic [2:0] {
    SSX_OP_NONE  = 3'h0,
    SSX_OP_SUBL  = 3'h1,
    SSX_OP_SUBR  = 3'h2,
    SSX_OP_SWAP  = 3'h3,
    SSX_OP_SLEEP = 3'h4
  } ssx_op_e;
endpackage

// >>> tb_top.sv
`timescale 1ns/100ps
// Directed bench for the core
module tb_top;
  logic        core_clk = 1'b0;      // Core clock
  logic        nrst = 1'b0;          // Reset, active low
  logic [13:0] instr_word = 14'h0000; // Instruction
  logic        instr_valid = 1'b0;   // Instruction qualifier
  logic [7:0]  file_rdata = 8'h00;   // File read data
  logic [6:0]  file_addr;            // File address
  logic [7:0]  acc, file_wdata, watchdog_counter, watchdog_prescaler; // Data outputs
  logic        file_we, carry_flag, digit_carry_flag, zero_flag; // Write and flags
  logic        timeout_status_bit, powerdown_status_bit, sleep_state; // Power status
  logic [3:0]  phase;                // Phase indicator
  logic [7:0]  e_acc = 8'h00;        // Expected accumulator
  logic        e_c, e_dc, e_z;       // Expected flags
  int          error_cnt, samples_checked; // Counters
  // Literal operand for each step of the literal test; the last step gives zero
  function automatic logic [7:0] lit_at(input int i);
    case (i)
      0:       return 8'h03;
      1:       return 8'h02;
      2:       return 8'h10;
      3:       return 8'hff;
      default: return 8'hee;
    endcase
  endfunction
  ssx_core dut (.core_clk, .nrst, .instr_word, .instr_valid, .file_rdata, .file_addr,
    .file_wdata, .file_we, .acc, .carry_flag, .digit_carry_flag, .zero_flag,
    .timeout_status_bit, .powerdown_status_bit, .sleep_state, .watchdog_counter,
    .watchdog_prescaler, .phase);
  // Clock, 8 ns period
  always #4 core_clk = ~core_clk;
  // Compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Issue one instruction at phase one, then scramble the inputs
  task exec(input logic [13:0] w, input logic [7:0] f);
    for (int i = 0; i < 8 && phase !== 4'h1; i++) @(negedge core_clk);
    if (phase !== 4'h1) begin
      error_cnt++;
      report_and_stop;
    end
    instr_word = w;
    instr_valid = 1'b1;
    file_rdata = f;
    @(negedge core_clk);
    instr_valid = 1'b0;
    instr_word = ~w;
    @(negedge core_clk);
    file_rdata = ~f;
    repeat (2) @(negedge core_clk);
  endtask
  // Run and compare accumulator and flags
  task run(input logic [13:0] w, input logic [7:0] f);
    exec(w, f);
    chk(acc, e_acc);
    chk(carry_flag, e_c);
    chk(digit_carry_flag, e_dc);
    chk(zero_flag, e_z);
  endtask
  // Expected a minus b and its flags
  task sub(input logic [7:0] a, input logic [7:0] b, output logic [7:0] r);
    r = a - b;
    e_c = a >= b;
    e_dc = a[3:0] >= b[3:0];
    e_z = r == 8'h00;
  endtask
  // Literal subtract, both values of the ignored bit
  task t_lit;
    for (int i = 0; i < 5; i++) begin
      sub(lit_at(i), e_acc, e_acc);
      run({5'h1e, i[0], lit_at(i)}, 8'h00);
      chk(file_we, 1'b0);
    end
    $display("literal subtract done");
  endtask
  // Register subtract to each destination
  task t_reg;
    logic [7:0] r;
    sub(8'h35, e_acc, e_acc);
    run(14'h0211, 8'h35);
    sub(8'h22, e_acc, r);
    run(14'h02da, 8'h22);
    chk(file_we, 1'b1);
    chk(file_wdata, r);
    chk(file_addr, 8'h5a);
    $display("register subtract done");
  endtask
  // Nibble swap to each destination, then an unhandled opcode
  task t_swap;
    e_acc = 8'h5a;
    run(14'h0e07, 8'ha5);
    run(14'h0e85, 8'h3c);
    chk(file_wdata, 8'hc3);
    chk(file_we, 1'b1);
    run(14'h3a55, 8'h00);
    $display("swap done");
  endtask
  // Sleep entry, then later instructions ignored
  task t_sleep;
    exec(14'h0063, 8'h00);
    chk(sleep_state, 1'b1);
    chk(timeout_status_bit, 1'b1);
    chk(powerdown_status_bit, 1'b0);
    chk(watchdog_counter, 8'h00);
    chk(watchdog_prescaler, 8'h00);
    instr_word = 14'h3cff;
    instr_valid = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(acc, e_acc);
    $display("sleep done");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    chk(powerdown_status_bit, 1'b1);
    chk(sleep_state, 1'b0);
    chk(acc, 8'h00);
    t_lit;
    t_reg;
    t_swap;
    t_sleep;
    report_and_stop;
  end
endmodule
